// ---- include/slpdg_consts.vh ----
// constants for the sleep-mode domain gating block
`ifndef SLPDG_CONSTS_VH
`define SLPDG_CONSTS_VH

// register byte offsets (haddr[7:0])
`define SLPDG_ADDR_CTRL 8'h00
`define SLPDG_ADDR_CMD 8'h04
`define SLPDG_ADDR_STATUS 8'h08
`define SLPDG_ADDR_DOMAIN 8'h0C

// control register fields
`define SLPDG_CTRL_W 7
`define SLPDG_CTRL_RST 7'h00
`define SLPDG_CTRL_MODE_LSB 0
`define SLPDG_CTRL_MODE_MSB 2
`define SLPDG_CTRL_SLEEP_EN 3
`define SLPDG_CTRL_WDT_KEEP 4
`define SLPDG_CTRL_SYMC_KEEP 5
`define SLPDG_CTRL_LFXO_KEEP 6

// command register fields
`define SLPDG_CMD_SLEEP 0

// status register fields
`define SLPDG_STAT_ASLEEP 0
`define SLPDG_STAT_MODE_LSB 1
`define SLPDG_STAT_MODE_MSB 3
`define SLPDG_STAT_WOKE 4
`define SLPDG_STAT_ERR 5

// sleep mode encodings
`define SLPDG_MODE_IDLE 3'h0
`define SLPDG_MODE_ADCNR 3'h1
`define SLPDG_MODE_PDOWN 3'h2
`define SLPDG_MODE_PSAVE 3'h3
`define SLPDG_MODE_STBY 3'h4
`define SLPDG_MODE_XSTBY 3'h5
`define SLPDG_MODE_DEEP 3'h6
`define SLPDG_MODE_BAD 3'h7

// domain enable vector bit positions
`define SLPDG_DOM_W 13
`define SLPDG_DOM_CPU 0
`define SLPDG_DOM_SRAM 1
`define SLPDG_DOM_TMR 2
`define SLPDG_DOM_SPI 3
`define SLPDG_DOM_IRQ 4
`define SLPDG_DOM_ATMR 5
`define SLPDG_DOM_ADC 6
`define SLPDG_DOM_MOSC 7
`define SLPDG_DOM_RCOSC 8
`define SLPDG_DOM_WDT 9
`define SLPDG_DOM_SYMC 10
`define SLPDG_DOM_LFXO 11
`define SLPDG_DOM_SUPPLY 12

// domain vectors for run, empty sleep base and wake phase
`define SLPDG_DOM_ALL 13'h1FFF
`define SLPDG_DOM_NONE 13'h0000
`define SLPDG_DOM_WAKE 13'h1F80

// oscillator settle countdown loaded on wake; clocks restart one cycle after it reaches zero
`define SLPDG_SETTLE 4'h8

`endif

// ---- rtl/slpdg_wake_sync.v ----
// two-flop synchroniser for the asynchronous wake request
`include "slpdg_consts.vh"
module slpdg_wake_sync (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // asynchronous level in, synchronous level out
    input wire async_in,
    output reg sync_out
);

    reg meta; // first stage, read only by second stage

    // two flip-flops in series
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end

endmodule

// ---- rtl/slpdg_mode_decode.v ----
// maps a sleep mode and its keep bits to domain enables
`include "slpdg_consts.vh"
module slpdg_mode_decode (
    // selected mode and deep-sleep keep options
    input wire [2:0] mode,
    input wire wdt_keep,
    input wire symc_keep,
    input wire lfxo_keep,
    // domain enables while asleep
    output reg [12:0] dom
);

    // combinational table of surviving domains per mode
    always @* begin
        dom = `SLPDG_DOM_NONE;
        // own-oscillator blocks run in every shallow mode
        dom[`SLPDG_DOM_WDT] = 1'b1;
        dom[`SLPDG_DOM_SYMC] = 1'b1;
        dom[`SLPDG_DOM_SUPPLY] = 1'b1;
        case (mode)
            `SLPDG_MODE_IDLE: begin
                // only the core stops
                dom = `SLPDG_DOM_ALL;
                dom[`SLPDG_DOM_CPU] = 1'b0;
            end
            `SLPDG_MODE_ADCNR: begin
                // async timer and adc on a live oscillator
                dom[`SLPDG_DOM_ATMR] = 1'b1;
                dom[`SLPDG_DOM_ADC] = 1'b1;
                dom[`SLPDG_DOM_MOSC] = 1'b1;
                dom[`SLPDG_DOM_LFXO] = 1'b1;
            end
            `SLPDG_MODE_PDOWN: begin
                // oscillators off, supply kept for retention
                dom[`SLPDG_DOM_MOSC] = 1'b0;
            end
            `SLPDG_MODE_PSAVE: begin
                // timebase kept on the low-frequency crystal
                dom[`SLPDG_DOM_ATMR] = 1'b1;
                dom[`SLPDG_DOM_LFXO] = 1'b1;
            end
            `SLPDG_MODE_STBY: begin
                // rc oscillator left running for fast start
                dom[`SLPDG_DOM_RCOSC] = 1'b1;
            end
            `SLPDG_MODE_XSTBY: begin
                // rc oscillator and async timer both run
                dom[`SLPDG_DOM_RCOSC] = 1'b1;
                dom[`SLPDG_DOM_ATMR] = 1'b1;
                dom[`SLPDG_DOM_LFXO] = 1'b1;
            end
            `SLPDG_MODE_DEEP: begin
                // main supply cut
                dom[`SLPDG_DOM_SUPPLY] = 1'b0;
                // survivors chosen by software
                dom[`SLPDG_DOM_WDT] = wdt_keep;
                dom[`SLPDG_DOM_SYMC] = symc_keep;
                dom[`SLPDG_DOM_LFXO] = lfxo_keep;
            end
            default: begin
                // unused code never reaches sleep
                dom = `SLPDG_DOM_ALL;
            end
        endcase
    end

endmodule

// ---- rtl/slpdg_top.v ----
// sleep-mode controller with ahb-lite registers and domain gates
//
// The AHB-Lite interface to the registers and the placing of the registers were decided locally.
`include "slpdg_consts.vh"
module slpdg_top (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // ahb-lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    // asynchronous wake request from the interrupt sources
    input wire wake_irq,
    // clock gates
    output wire cpu_clk_en,
    output wire sram_clk_en,
    output wire tmr_clk_en,
    output wire spi_clk_en,
    output wire irq_clk_en,
    output wire atmr_clk_en,
    output wire adc_clk_en,
    // oscillator enables
    output wire mosc_en,
    output wire rcosc_en,
    output wire wdt_en,
    output wire symc_en,
    output wire lfxo_en,
    // main supply switch
    output wire supply_en
);

    // one-hot sequencer states
    localparam [2:0] ST_RUN = 3'b001;
    localparam [2:0] ST_SLEEP = 3'b010;
    localparam [2:0] ST_WAKE = 3'b100;

    // register select codes, one-hot
    localparam [3:0] SEL_CTRL = 4'b0001;
    localparam [3:0] SEL_CMD = 4'b0010;
    localparam [3:0] SEL_STAT = 4'b0100;
    localparam [3:0] SEL_DOM = 4'b1000;
    localparam [3:0] SEL_NONE = 4'b0000;

    // address to one-hot register select
    function [3:0] reg_sel;
        input [7:0] a;
        begin
            if (a == `SLPDG_ADDR_CTRL) begin
                reg_sel = SEL_CTRL;
            end else if (a == `SLPDG_ADDR_CMD) begin
                reg_sel = SEL_CMD;
            end else if (a == `SLPDG_ADDR_STATUS) begin
                reg_sel = SEL_STAT;
            end else if (a == `SLPDG_ADDR_DOMAIN) begin
                reg_sel = SEL_DOM;
            end else begin
                reg_sel = SEL_NONE;
            end
        end
    endfunction

    // software-visible state
    reg [6:0] ctrl; // mode, sleep enable, keep bits
    reg woke; // sticky: a wake completed
    reg err; // sticky: sleep request refused
    // sequencer state
    reg [2:0] state;
    reg [2:0] next_state;
    reg [3:0] cnt; // settle countdown
    reg [3:0] next_cnt;
    reg [5:0] cfg; // mode and keeps latched at entry
    reg [12:0] dom; // registered domain enables
    reg [12:0] next_dom;
    // ahb data-phase bookkeeping
    reg dph_wr; // write data phase pending
    reg [3:0] dph_sel; // register of that write

    // address-phase qualifiers
    wire aph_take;
    wire [3:0] aph_sel;
    // write strobes in the data phase
    wire wr_ctrl;
    wire wr_cmd;
    wire wr_stat;
    // sleep request decode
    wire sleep_req;
    wire mode_ok;
    wire sleep_go;
    wire sleep_bad;
    // wake path
    wire wake_s;
    wire wake_done;
    // decoder interface
    wire [2:0] dec_mode;
    wire [2:0] dec_keep;
    wire [12:0] sleep_dom;

    // zero-wait slave, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // transfer accepted on nonseq or seq with hready
    assign aph_take = hsel & hready & htrans[1];
    assign aph_sel = reg_sel(haddr[7:0]);

    // data-phase write strobes
    assign wr_ctrl = dph_wr & (dph_sel == SEL_CTRL);
    assign wr_cmd = dph_wr & (dph_sel == SEL_CMD);
    assign wr_stat = dph_wr & (dph_sel == SEL_STAT);

    // sleep accepted only for a defined mode with enable set
    assign sleep_req = wr_cmd & hwdata[`SLPDG_CMD_SLEEP];
    assign mode_ok = ctrl[`SLPDG_CTRL_MODE_MSB:`SLPDG_CTRL_MODE_LSB] != `SLPDG_MODE_BAD;
    assign sleep_go = sleep_req & mode_ok & ctrl[`SLPDG_CTRL_SLEEP_EN] & (state == ST_RUN);
    assign sleep_bad = sleep_req & ~sleep_go;

    // settle finished, clocks restart next edge
    assign wake_done = (state == ST_WAKE) & (cnt == 4'h0);

    // decoder sees live control while running, latched set otherwise
    assign dec_mode = (state == ST_RUN) ? ctrl[2:0] : cfg[2:0];
    assign dec_keep = (state == ST_RUN) ? ctrl[6:4] : cfg[5:3];

    // wake request crosses into hclk
    slpdg_wake_sync u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in(wake_irq),
        .sync_out(wake_s)
    );

    // per-mode table of surviving domains
    slpdg_mode_decode u_dec (
        .mode(dec_mode),
        .wdt_keep(dec_keep[0]),
        .symc_keep(dec_keep[1]),
        .lfxo_keep(dec_keep[2]),
        .dom(sleep_dom)
    );

    // sequencer next state and domain vector
    always @* begin
        next_state = state;
        next_cnt = cnt;
        next_dom = dom;
        case (state)
            ST_RUN: begin
                // everything clocked while running
                next_dom = `SLPDG_DOM_ALL;
                if (sleep_go) begin
                    // gate per the chosen mode
                    next_state = ST_SLEEP;
                    next_dom = sleep_dom;
                end
            end
            ST_SLEEP: begin
                // hold gates until an interrupt arrives
                next_dom = sleep_dom;
                if (wake_s) begin
                    // supply and oscillators back first
                    next_state = ST_WAKE;
                    next_cnt = `SLPDG_SETTLE;
                    next_dom = `SLPDG_DOM_WAKE;
                end
            end
            ST_WAKE: begin
                // wait for oscillators, then restart clocks
                next_dom = `SLPDG_DOM_WAKE;
                if (cnt == 4'h0) begin
                    next_state = ST_RUN;
                    next_dom = `SLPDG_DOM_ALL;
                end else begin
                    next_cnt = cnt - 4'h1;
                end
            end
            default: begin
                // illegal code recovers to run
                next_state = ST_RUN;
                next_dom = `SLPDG_DOM_ALL;
            end
        endcase
    end

    // sequencer registers; hardware reset is also a wake
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= ST_RUN;
            cnt <= 4'h0;
            dom <= `SLPDG_DOM_ALL;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            dom <= next_dom;
        end
    end

    // mode and keeps frozen for the whole sleep
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg <= 6'h00;
        end else if (sleep_go) begin
            cfg <= {ctrl[6:4], ctrl[2:0]};
        end
    end

    // ahb address phase captured for the write data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_wr <= 1'b0;
            dph_sel <= SEL_NONE;
        end else begin
            dph_wr <= aph_take & hwrite;
            dph_sel <= aph_sel;
        end
    end

    // control register; not touched by sleep or wake
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= `SLPDG_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl <= hwdata[6:0];
        end
    end

    // sticky flags, set wins over write-one-to-clear
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            woke <= 1'b0;
            err <= 1'b0;
        end else begin
            if (wake_done) begin
                woke <= 1'b1;
            end else if (wr_stat & hwdata[`SLPDG_STAT_WOKE]) begin
                woke <= 1'b0;
            end
            if (sleep_bad) begin
                err <= 1'b1;
            end else if (wr_stat & hwdata[`SLPDG_STAT_ERR]) begin
                err <= 1'b0;
            end
        end
    end

    // read data registered in the address phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (aph_take & ~hwrite) begin
            hrdata <= 32'h00000000;
            if (aph_sel == SEL_CTRL) begin
                // control as written
                hrdata[6:0] <= ctrl;
            end else if (aph_sel == SEL_STAT) begin
                // sequencer and sticky flags
                hrdata[`SLPDG_STAT_ASLEEP] <= (state != ST_RUN);
                hrdata[`SLPDG_STAT_MODE_MSB:`SLPDG_STAT_MODE_LSB] <= cfg[2:0];
                hrdata[`SLPDG_STAT_WOKE] <= woke;
                hrdata[`SLPDG_STAT_ERR] <= err;
            end else if (aph_sel == SEL_DOM) begin
                // live domain enables
                hrdata[12:0] <= dom;
            end
        end
    end

    // idle keeps sram, timers, spi, irq; core stops
    assign cpu_clk_en = dom[`SLPDG_DOM_CPU];
    assign sram_clk_en = dom[`SLPDG_DOM_SRAM];
    assign tmr_clk_en = dom[`SLPDG_DOM_TMR];
    assign spi_clk_en = dom[`SLPDG_DOM_SPI];
    assign irq_clk_en = dom[`SLPDG_DOM_IRQ];
    // async timer in save, noise-reduction, extended standby
    assign atmr_clk_en = dom[`SLPDG_DOM_ATMR];
    // converter clock alive in noise reduction
    assign adc_clk_en = dom[`SLPDG_DOM_ADC];
    // oscillators
    assign mosc_en = dom[`SLPDG_DOM_MOSC];
    assign rcosc_en = dom[`SLPDG_DOM_RCOSC];
    // deep-sleep survivors
    assign wdt_en = dom[`SLPDG_DOM_WDT];
    assign symc_en = dom[`SLPDG_DOM_SYMC];
    assign lfxo_en = dom[`SLPDG_DOM_LFXO];
    // main supply switch
    assign supply_en = dom[`SLPDG_DOM_SUPPLY];

endmodule

// ---- sim/slpdg_assertions.sv ----
// checker of the domain gate outputs against the mode table
module slpdg_chk (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // wake request
    input wire wake_irq,
    // clock gates
    input wire cpu_clk_en,
    input wire sram_clk_en,
    input wire tmr_clk_en,
    input wire spi_clk_en,
    input wire irq_clk_en,
    input wire atmr_clk_en,
    input wire adc_clk_en,
    // oscillators and supply
    input wire mosc_en,
    input wire rcosc_en,
    input wire wdt_en,
    input wire symc_en,
    input wire lfxo_en,
    input wire supply_en
);
    timeunit 1ns;
    timeprecision 1ps;
    // enables gathered in domain register order
    wire [12:0] dom = {supply_en, lfxo_en, symc_en, wdt_en, rcosc_en, mosc_en, adc_clk_en,
        atmr_clk_en, irq_clk_en, spi_clk_en, tmr_clk_en, sram_clk_en, cpu_clk_en};
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // entry into the oscillator settle phase
    sequence s_wake_in;
        $rose(dom == 13'h1F80);
    endsequence
    // full run vector returns after the settle count
    sequence s_run_back;
        ##[8:10] dom == 13'h1FFF;
    endsequence
    AST_IDLE_KEEP: assert property (!cpu_clk_en && sram_clk_en |-> dom == 13'h1FFE)
        else $error("idle gating wrong");
    AST_PDOWN_STOP: assert property (supply_en && !mosc_en && !rcosc_en && !atmr_clk_en |-> dom == 13'h1600)
        else $error("power-down gating wrong");
    AST_PDOWN_HOLD: assert property (dom == 13'h1600 && !wake_irq && !$past(wake_irq) |=> dom == 13'h1600)
        else $error("power-down left without wake");
    AST_PSAVE_TMR: assert property (supply_en && !mosc_en && !rcosc_en && atmr_clk_en |-> dom == 13'h1E20)
        else $error("power-save gating wrong");
    AST_ADCNR_ONLY: assert property (adc_clk_en && !cpu_clk_en && !sram_clk_en |-> dom == 13'h1EE0)
        else $error("noise mode gating wrong");
    AST_STBY_RC: assert property (rcosc_en && !mosc_en && !atmr_clk_en |-> dom == 13'h1700)
        else $error("standby gating wrong");
    AST_XSTBY_RC: assert property (rcosc_en && !mosc_en && atmr_clk_en |-> dom == 13'h1F20)
        else $error("extended standby gating wrong");
    AST_DEEP_CUT: assert property (!supply_en |-> dom[8:0] == 9'h000)
        else $error("deep sleep left a block powered");
    AST_WAKE_RUN: assert property (s_wake_in |-> s_run_back)
        else $error("clocks not restarted after wake");
    AST_WAKE_CAUSE: assert property (s_wake_in |-> $past(wake_irq, 2))
        else $error("wake phase without a wake request");
endmodule

bind slpdg_top slpdg_chk u_chk (.hclk(hclk), .hresetn(hresetn), .wake_irq(wake_irq),
    .cpu_clk_en(cpu_clk_en), .sram_clk_en(sram_clk_en), .tmr_clk_en(tmr_clk_en),
    .spi_clk_en(spi_clk_en), .irq_clk_en(irq_clk_en), .atmr_clk_en(atmr_clk_en),
    .adc_clk_en(adc_clk_en), .mosc_en(mosc_en), .rcosc_en(rcosc_en), .wdt_en(wdt_en),
    .symc_en(symc_en), .lfxo_en(lfxo_en), .supply_en(supply_en));

// ---- sim/tb.sv ----
// self-checking bench of the sleep-mode controller
`include "slpdg_consts.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // bus and wake drive
    logic hclk, hresetn, hsel, hwrite, wake_irq;
    logic [31:0] haddr, hwdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    // design outputs
    wire [31:0] hrdata;
    wire hreadyout, hresp;
    wire [12:0] dom;
    int n_errors, compares;

    // device under test, enables gathered into dom
    slpdg_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .wake_irq(wake_irq), .cpu_clk_en(dom[0]),
        .sram_clk_en(dom[1]), .tmr_clk_en(dom[2]), .spi_clk_en(dom[3]), .irq_clk_en(dom[4]),
        .atmr_clk_en(dom[5]), .adc_clk_en(dom[6]), .mosc_en(dom[7]), .rcosc_en(dom[8]),
        .wdt_en(dom[9]), .symc_en(dom[10]), .lfxo_en(dom[11]), .supply_en(dom[12]));

    // 40 MHz clock
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    // verdict and end of run
    task finish_test;
        if (n_errors == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // compare one value
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one single ahb-lite transfer, read data left in rd
    task bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask

    // expected sleep enables for a mode and keep bits
    function logic [12:0] exp_dom(input logic [2:0] m, input logic [2:0] k);
        case (m)
            3'h0: exp_dom = 13'h1FFE;
            3'h1: exp_dom = 13'h1EE0;
            3'h2: exp_dom = 13'h1600;
            3'h3: exp_dom = 13'h1E20;
            3'h4: exp_dom = 13'h1700;
            3'h5: exp_dom = 13'h1F20;
            default: exp_dom = {1'b0, k, 9'h000};
        endcase
    endfunction

    // raise wake until the run vector returns
    task wake_up;
        int i;
        wake_irq <= 1'b1;
        for (i = 0; i < 40 && dom !== 13'h1FFF; i++) @(negedge hclk);
        @(posedge hclk);
        wake_irq <= 1'b0;
        chk({19'h0, dom}, 32'h1FFF);
    endtask

    // sleep in one mode, check gates and status, wake
    task sleep_in(input logic [2:0] m, input logic [2:0] k);
        logic [31:0] c;
        c = {25'h0, k, 1'b1, m};
        bus(`SLPDG_ADDR_CTRL, 1'b1, c);
        bus(`SLPDG_ADDR_CMD, 1'b1, 32'h1);
        @(negedge hclk);
        chk({19'h0, dom}, {19'h0, exp_dom(m, k)});
        bus(`SLPDG_ADDR_DOMAIN, 1'b0, 32'h0);
        chk(rd, {19'h0, exp_dom(m, k)});
        bus(`SLPDG_ADDR_STATUS, 1'b0, 32'h0);
        chk(rd, {28'h0, m, 1'b1});
        wake_up;
        bus(`SLPDG_ADDR_STATUS, 1'b0, 32'h0);
        chk(rd, {27'h0, 1'b1, m, 1'b0});
        bus(`SLPDG_ADDR_STATUS, 1'b1, 32'h10);
        bus(`SLPDG_ADDR_CTRL, 1'b0, 32'h0);
        chk(rd, c);
    endtask

    // reset values, reserved bits, write-only and unmapped places
    task test_regs;
        chk({19'h0, dom}, 32'h1FFF);
        bus(`SLPDG_ADDR_CTRL, 1'b0, 32'h0);
        chk(rd, 32'h0);
        bus(`SLPDG_ADDR_CTRL, 1'b1, 32'hFFFFFFFF);
        bus(`SLPDG_ADDR_CTRL, 1'b0, 32'h0);
        chk(rd, 32'h7F);
        bus(`SLPDG_ADDR_CTRL, 1'b1, 32'h0);
        bus(`SLPDG_ADDR_CMD, 1'b0, 32'h0);
        chk(rd, 32'h0);
        bus(8'h10, 1'b1, 32'hFFFFFFFF);
        bus(8'h10, 1'b0, 32'h0);
        chk(rd, 32'h0);
        bus(`SLPDG_ADDR_STATUS, 1'b0, 32'h0);
        chk(rd, 32'h0);
    endtask

    // every mode, deep sleep with both keep patterns
    task test_modes;
        for (int m = 0; m < 6; m++) sleep_in(m[2:0], 3'h0);
        sleep_in(3'h6, 3'h5);
        sleep_in(3'h6, 3'h2);
    endtask

    // refused requests and a request while asleep
    task test_refuse;
        bus(`SLPDG_ADDR_CTRL, 1'b1, 32'hF);
        bus(`SLPDG_ADDR_CMD, 1'b1, 32'h1);
        @(negedge hclk);
        chk({19'h0, dom}, 32'h1FFF);
        bus(`SLPDG_ADDR_STATUS, 1'b0, 32'h0);
        chk(rd & 32'h21, 32'h20);
        bus(`SLPDG_ADDR_STATUS, 1'b1, 32'h20);
        bus(`SLPDG_ADDR_CTRL, 1'b1, 32'h2);
        bus(`SLPDG_ADDR_CMD, 1'b1, 32'h1);
        bus(`SLPDG_ADDR_STATUS, 1'b0, 32'h0);
        chk(rd & 32'h21, 32'h20);
        bus(`SLPDG_ADDR_STATUS, 1'b1, 32'h20);
        bus(`SLPDG_ADDR_CTRL, 1'b1, 32'hA);
        bus(`SLPDG_ADDR_CMD, 1'b1, 32'h1);
        bus(`SLPDG_ADDR_CMD, 1'b1, 32'h1);
        repeat (20) @(negedge hclk);
        chk({19'h0, dom}, 32'h1600);
        wake_up;
        bus(`SLPDG_ADDR_STATUS, 1'b0, 32'h0);
        chk(rd, 32'h34);
        bus(`SLPDG_ADDR_STATUS, 1'b1, 32'h30);
        bus(`SLPDG_ADDR_STATUS, 1'b0, 32'h0);
        chk(rd, 32'h4);
    endtask

    // hardware reset in mid-sleep restores clocks and clears state
    task test_reset;
        bus(`SLPDG_ADDR_CTRL, 1'b1, 32'h4B);
        bus(`SLPDG_ADDR_CMD, 1'b1, 32'h1);
        @(negedge hclk);
        chk({19'h0, dom}, 32'h1E20);
        @(posedge hclk);
        hresetn <= 1'b0;
        @(negedge hclk);
        chk({19'h0, dom}, 32'h1FFF);
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        bus(`SLPDG_ADDR_CTRL, 1'b0, 32'h0);
        chk(rd, 32'h0);
        bus(`SLPDG_ADDR_STATUS, 1'b0, 32'h0);
        chk(rd, 32'h0);
        sleep_in(3'h2, 3'h0);
    endtask

    // main sequence
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        wake_irq = 1'b0;
        n_errors = 0;
        compares = 0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        test_regs;
        test_modes;
        test_refuse;
        test_reset;
        finish_test;
    end

    // watchdog against a hang
    initial begin
        repeat (5000) @(posedge hclk);
        n_errors++;
        finish_test;
    end
endmodule
